// *** common/fram_cmd_map.svh ***
// Offsets-free constant map for the two-wire command-extension block.
// Assumes inclusion by bare name; holds only macro definitions.
`ifndef FRAM_CMD_MAP_SVH
`define FRAM_CMD_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing figures.
// ----------------------------------------------------------------------
`define REF_CLK_PERIOD_NS           5
`define SPIKE_FILTER_WIDTH_NS       50
`define SPIKE_FILTER_WIDTH_HS_NS    5
`define SLEEP_RECOVERY_INTERVAL_US  100

// Least times round up to whole reference clock cycles.
`define SPIKE_CYCLES_STD \
  ((`SPIKE_FILTER_WIDTH_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define SPIKE_CYCLES_HS \
  ((`SPIKE_FILTER_WIDTH_HS_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// Longest time rounds down to whole reference clock cycles.
`define SLEEP_RECOVERY_CYCLES \
  ((`SLEEP_RECOVERY_INTERVAL_US * 1000) / `REF_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Byte codes and address fields.
// ----------------------------------------------------------------------
`define RSV_PREFIX_BYTE     8'hF8
`define RSV_ID_READ_BYTE    8'hF9
`define DEV_TYPE_CODE       4'hA
`define ACK_BIT_INDEX       4'h8
`define LAST_DATA_BIT       4'h7
`define WAKE_COMPARE_BIT    4'h6
`define LAST_ID_BYTE        2'h2
`define SOFT_RESET_CLOCKS   4'h9

`endif

// *** common/fram_cmd_pkg.sv ***
// Types shared by the command-extension block.
// Assumes nothing of its surroundings.
package fram_cmd_pkg;

  // ----------------------------------------------------------------------
  // Bus sequencer states, one-hot.
  // ----------------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE       = 10'h001,
    ST_ADDR       = 10'h002,
    ST_RSV_ADDR   = 10'h004,
    ST_RSV_WAIT   = 10'h008,
    ST_RSV_CMD    = 10'h010,
    ST_ID_TX      = 10'h020,
    ST_SLEEP_PEND = 10'h040,
    ST_SLEEP      = 10'h080,
    ST_WAKE_ADDR  = 10'h100,
    ST_RECOVER    = 10'h200
  } bus_state_type;

endpackage

// *** hdl/bus_line_filter.sv ***
// Synchroniser and spike filter for one bus line.
// Assumes raw comes from a pin and hs_mode from logic on ref_clk.
`timescale 1ns/1ps
`include "fram_cmd_map.svh"

module bus_line_filter (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic raw_in,
  input  wire logic hs_mode,
  output logic      level_q
);

  logic       meta_q;
  logic       sync_q;
  logic [3:0] cnt_q;
  logic [3:0] limit;

  // Shorter filter window in high-speed mode.
  assign limit = hs_mode ? 4'(`SPIKE_CYCLES_HS) : 4'(`SPIKE_CYCLES_STD);

  // Two flip-flops bring the pin into the clock domain; idle bus is high.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  // A new level is taken only after it stood for the whole window.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q   <= 4'h0;
      level_q <= 1'b1;
    end else if (sync_q == level_q) begin
      cnt_q <= 4'h0;
    end else if (4'(cnt_q + 4'h1) >= limit) begin
      cnt_q   <= 4'h0;
      level_q <= sync_q;
    end else begin
      cnt_q <= 4'(cnt_q + 4'h1);
    end
  end

endmodule

// *** hdl/fram_id_sleep_ctrl.sv ***
// Command-extension logic of a two-wire serial memory slave: identity
// read, sleep entry, wake on own address, recovery timing, soft reset.
// Assumes a master on the bus lines and the memory core beside it.
`timescale 1ns/1ps
`include "fram_cmd_map.svh"

// Summary of operation
// - Identity is 12-bit maker field then 12-bit type, sent as three bytes.
// - Start, 0xF8, then slave address ignoring bit 16 and direction; ack both.
// - Repeated start, 0xF9 acknowledged, then three identity bytes are driven.
// - Repeated start and 0xF8 again acknowledged, then the device sleeps.
// - Asleep, own address match starts waking at sixth clock falling edge.
// - Asleep, a foreign address leaves the device asleep without recovery.
// - Recovery to standby ends within 100 microseconds.
// - Stop conditions are ignored while the waking address comes in.
// - After recovery the own address is acknowledged as in standby.
// - Spikes under 50 ns, or 5 ns in high speed, are filtered out.
// - Software reset, nine released clocks then start, pulses soft_reset_q in standby.
// - Address byte is 1010, two select pins, bit 16, then direction.
// - After waking the address pointer is undefined until the master sets it.
// - Bytes are eight bits; the receiver pulls data low on the ninth clock.
module fram_id_sleep_ctrl #(
  parameter int unsigned RECOVERY_CYCLES = `SLEEP_RECOVERY_CYCLES,
  parameter logic [11:0] MANUFACTURER_ID = 12'h5A3, // Arbitrary value.
  parameter logic [11:0] DEVICE_TYPE_ID  = 12'h2C7  // Arbitrary value.
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  input  wire logic address_select_pin_low,
  input  wire logic address_select_pin_high,
  input  wire logic hs_mode,
  output logic      sleeping,
  output logic      recovering,
  output logic      standby_ready,
  output logic      mem_cmd_sel_q,
  output logic      mem_cmd_read_q,
  output logic      memory_address_bit16_q,
  output logic      ptr_undefined_q,
  output logic      soft_reset_q
);

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  fram_cmd_pkg::bus_state_type state_q;

  logic        scl_f;
  logic        sda_f;
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic [1:0]  sel_meta_q;
  logic [1:0]  sel_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        own_addr;
  logic        wake_match;
  logic        ack_now;
  logic        ack_pend_q;
  logic        drive_q;
  logic [1:0]  id_byte_q;
  logic        id_sent_q;
  logic [23:0] id_word;
  logic [7:0]  tx_byte;
  logic        tx_bit;
  logic        master_ack_clk;
  logic        id_done;
  logic [14:0] rec_cnt_q;
  logic        rec_done;
  logic [3:0]  sr_cnt_q;

  // ----------------------------------------------------------------------
  // Line conditioning and bus event detection.
  // ----------------------------------------------------------------------

  // Each line is synchronised and spike filtered.
  bus_line_filter scl_filter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .raw_in  (scl_in),
    .hs_mode (hs_mode),
    .level_q (scl_f)
  );

  bus_line_filter sda_filter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .raw_in  (sda_in),
    .hs_mode (hs_mode),
    .level_q (sda_f)
  );

  // Previous filtered levels for edge detection.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  // Address select pins pass two flip-flops.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_meta_q <= 2'h0;
      sel_q      <= 2'h0;
    end else begin
      sel_meta_q <= {address_select_pin_high, address_select_pin_low};
      sel_q      <= sel_meta_q;
    end
  end

  // Clock edges and start or stop while the clock stays high.
  assign scl_rise   = scl_f & ~scl_prev_q;
  assign scl_fall   = ~scl_f & scl_prev_q;
  assign start_cond = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_cond  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // ----------------------------------------------------------------------
  // Byte reception.
  // ----------------------------------------------------------------------

  // Bit counter runs 0 to 7 for data and 8 for the acknowledge clock.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end else if (start_cond) begin
      bit_cnt_q <= 4'h0;
    end else if (scl_rise) begin
      shift_q   <= {shift_q[6:0], sda_f};
      bit_cnt_q <= (bit_cnt_q == `ACK_BIT_INDEX) ? 4'h0 :
                   4'(bit_cnt_q + 4'h1);
    end
  end

  assign rx_byte   = {shift_q[6:0], sda_f};
  assign byte_done = scl_rise & (bit_cnt_q == `LAST_DATA_BIT);

  // Own address ignores bit 16 and the direction bit.
  assign own_addr = (rx_byte[7:4] == `DEV_TYPE_CODE) &
                    (rx_byte[3:2] == sel_q);
  assign wake_match = (shift_q[5:2] == `DEV_TYPE_CODE) &
                      (shift_q[1:0] == sel_q);

  // Bytes that the device acknowledges in each state.
  always_comb begin
    ack_now = 1'b0;
    if (byte_done) begin
      case (state_q)
        fram_cmd_pkg::ST_ADDR:
          ack_now = own_addr | (rx_byte == `RSV_PREFIX_BYTE);
        fram_cmd_pkg::ST_RSV_ADDR:
          ack_now = own_addr;
        fram_cmd_pkg::ST_RSV_CMD:
          ack_now = (rx_byte == `RSV_ID_READ_BYTE) |
                    (rx_byte == `RSV_PREFIX_BYTE);
        default:
          ack_now = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Identity transmission.
  // ----------------------------------------------------------------------
  assign id_word = {MANUFACTURER_ID, DEVICE_TYPE_ID};

  always_comb begin
    case (id_byte_q)
      2'h0:    tx_byte = id_word[23:16];
      2'h1:    tx_byte = id_word[15:8];
      default: tx_byte = id_word[7:0];
    endcase
  end

  assign tx_bit = tx_byte[3'(`LAST_DATA_BIT - bit_cnt_q)];

  // Master acknowledge clock of a byte the device has sent.
  assign master_ack_clk = scl_rise & (bit_cnt_q == `ACK_BIT_INDEX) &
                          (state_q == fram_cmd_pkg::ST_ID_TX) & id_sent_q;
  assign id_done = master_ack_clk & (sda_f | (id_byte_q == `LAST_ID_BYTE));

  // Byte index advances while the master acknowledges.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      id_byte_q <= 2'h0;
      id_sent_q <= 1'b0;
    end else if (byte_done && state_q == fram_cmd_pkg::ST_RSV_CMD) begin
      id_byte_q <= 2'h0;
      id_sent_q <= 1'b0;
    end else if (scl_fall && state_q == fram_cmd_pkg::ST_ID_TX &&
                 bit_cnt_q == 4'h0) begin
      id_sent_q <= 1'b1;
    end else if (master_ack_clk && !id_done) begin
      id_byte_q <= 2'(id_byte_q + 2'h1);
    end
  end

  // ----------------------------------------------------------------------
  // Data line drive.
  // ----------------------------------------------------------------------

  // Pending acknowledge is driven from the eighth falling edge.
  always_ff @(posedge ref_clk) begin
    if (reset || start_cond) begin
      ack_pend_q <= 1'b0;
    end else if (ack_now) begin
      ack_pend_q <= 1'b1;
    end else if (scl_fall && bit_cnt_q == `ACK_BIT_INDEX) begin
      ack_pend_q <= 1'b0;
    end
  end

  // Line changes only on falling clock edges; bus events release it.
  always_ff @(posedge ref_clk) begin
    if (reset || start_cond || stop_cond) begin
      drive_q <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt_q == `ACK_BIT_INDEX) begin
        drive_q <= ack_pend_q;
      end else if (state_q == fram_cmd_pkg::ST_ID_TX) begin
        drive_q <= ~tx_bit;
      end else begin
        drive_q <= 1'b0;
      end
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_q;

  // ----------------------------------------------------------------------
  // Command sequencer.
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= fram_cmd_pkg::ST_IDLE;
    end else if (start_cond) begin
      case (state_q)
        fram_cmd_pkg::ST_SLEEP,
        fram_cmd_pkg::ST_WAKE_ADDR: state_q <= fram_cmd_pkg::ST_WAKE_ADDR;
        fram_cmd_pkg::ST_RECOVER:   state_q <= fram_cmd_pkg::ST_RECOVER;
        fram_cmd_pkg::ST_SLEEP_PEND: state_q <= fram_cmd_pkg::ST_SLEEP;
        fram_cmd_pkg::ST_RSV_WAIT:  state_q <= fram_cmd_pkg::ST_RSV_CMD;
        default:                    state_q <= fram_cmd_pkg::ST_ADDR;
      endcase
    end else if (stop_cond) begin
      case (state_q)
        fram_cmd_pkg::ST_SLEEP,
        fram_cmd_pkg::ST_WAKE_ADDR,
        fram_cmd_pkg::ST_RECOVER:   state_q <= state_q;
        fram_cmd_pkg::ST_SLEEP_PEND: state_q <= fram_cmd_pkg::ST_SLEEP;
        default:                    state_q <= fram_cmd_pkg::ST_IDLE;
      endcase
    end else if (byte_done) begin
      case (state_q)
        fram_cmd_pkg::ST_ADDR:
          state_q <= (rx_byte == `RSV_PREFIX_BYTE) ?
                     fram_cmd_pkg::ST_RSV_ADDR : fram_cmd_pkg::ST_IDLE;
        fram_cmd_pkg::ST_RSV_ADDR:
          state_q <= own_addr ? fram_cmd_pkg::ST_RSV_WAIT :
                     fram_cmd_pkg::ST_IDLE;
        fram_cmd_pkg::ST_RSV_CMD:
          if (rx_byte == `RSV_ID_READ_BYTE) begin
            state_q <= fram_cmd_pkg::ST_ID_TX;
          end else if (rx_byte == `RSV_PREFIX_BYTE) begin
            state_q <= fram_cmd_pkg::ST_SLEEP_PEND;
          end else begin
            state_q <= fram_cmd_pkg::ST_IDLE;
          end
        default:
          state_q <= state_q;
      endcase
    end else if (scl_fall && state_q == fram_cmd_pkg::ST_SLEEP_PEND &&
                 bit_cnt_q == 4'h0) begin
      state_q <= fram_cmd_pkg::ST_SLEEP;
    end else if (scl_fall && state_q == fram_cmd_pkg::ST_WAKE_ADDR &&
                 bit_cnt_q == `WAKE_COMPARE_BIT) begin
      state_q <= wake_match ? fram_cmd_pkg::ST_RECOVER :
                 fram_cmd_pkg::ST_SLEEP;
    end else if (id_done) begin
      state_q <= fram_cmd_pkg::ST_IDLE;
    end else if (state_q == fram_cmd_pkg::ST_RECOVER && rec_done) begin
      state_q <= fram_cmd_pkg::ST_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Sleep recovery timer.
  // ----------------------------------------------------------------------
  assign rec_done = (rec_cnt_q == 15'(RECOVERY_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (reset || state_q != fram_cmd_pkg::ST_RECOVER) begin
      rec_cnt_q <= 15'h0000;
    end else if (!rec_done) begin
      rec_cnt_q <= 15'(rec_cnt_q + 15'h0001);
    end
  end

  // Pointer is undefined from power-on and after waking until written.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_undefined_q <= 1'b1;
    end else if (state_q == fram_cmd_pkg::ST_RECOVER && rec_done) begin
      ptr_undefined_q <= 1'b1;
    end else if (byte_done && state_q == fram_cmd_pkg::ST_ADDR &&
                 own_addr && !rx_byte[0]) begin
      ptr_undefined_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Normal address hand-over and software reset.
  // ----------------------------------------------------------------------

  // One-cycle select pulse to the memory core with the address fields.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_cmd_sel_q          <= 1'b0;
      mem_cmd_read_q         <= 1'b0;
      memory_address_bit16_q <= 1'b0;
    end else begin
      mem_cmd_sel_q <= byte_done & own_addr &
                       (state_q == fram_cmd_pkg::ST_ADDR);
      if (byte_done && own_addr && state_q == fram_cmd_pkg::ST_ADDR) begin
        mem_cmd_read_q         <= rx_byte[0];
        memory_address_bit16_q <= rx_byte[1];
      end
    end
  end

  // Counts clock pulses with the data line released; pulse on start.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sr_cnt_q     <= 4'h0;
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= start_cond & (sr_cnt_q == `SOFT_RESET_CLOCKS) &
                      standby_ready;
      if (start_cond || (scl_rise && !sda_f)) begin
        sr_cnt_q <= 4'h0;
      end else if (scl_rise && sr_cnt_q != `SOFT_RESET_CLOCKS) begin
        sr_cnt_q <= 4'(sr_cnt_q + 4'h1);
      end
    end
  end

  // Power state outputs decoded from the state register.
  assign sleeping   = (state_q == fram_cmd_pkg::ST_SLEEP) |
                      (state_q == fram_cmd_pkg::ST_WAKE_ADDR);
  assign recovering = (state_q == fram_cmd_pkg::ST_RECOVER);
  assign standby_ready = ~sleeping & ~recovering &
                         (state_q != fram_cmd_pkg::ST_SLEEP_PEND);

endmodule

// *** dv/fram_id_sleep_sva.sv ***
// Concurrent checks on the ports of the command-extension block.
// Assumes one reference clock and a synchronous active-high reset.
`timescale 1ns/1ps

module fram_id_sleep_sva #(
  parameter int unsigned RECOVERY_CYCLES = 50
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic sleeping,
  input wire logic recovering,
  input wire logic standby_ready,
  input wire logic mem_cmd_sel_q,
  input wire logic mem_cmd_read_q,
  input wire logic ptr_undefined_q,
  input wire logic soft_reset_q
);
  // ------------------------------------------------------------------
  // Recovery length counter
  // ------------------------------------------------------------------
  // Counts the cycles of the recovery interval now running.
  logic [31:0] rec_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (reset || !recovering) begin
      rec_cnt_q <= '0;
    end else begin
      rec_cnt_q <= rec_cnt_q + 32'h1;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_wake_begin;
    sleeping ##1 !sleeping;
  endsequence
  sequence s_recover_end;
    recovering ##1 !recovering;
  endsequence

  a_ack_low_only: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high while enabled");
  a_sel_one_pulse: assert property (mem_cmd_sel_q |=> !mem_cmd_sel_q)
    else $error("select pulse longer than one cycle");
  a_write_clears_ptr: assert property (
    mem_cmd_sel_q && !mem_cmd_read_q |-> ##[0:2] !ptr_undefined_q)
    else $error("write address left pointer flag set");
  a_sleep_not_ready: assert property (
    sleeping |-> !standby_ready && !recovering)
    else $error("sleep overlaps standby or recovery");
  a_wake_to_recover: assert property (s_wake_begin |-> recovering)
    else $error("sleep left without recovery");
  a_quiet_asleep: assert property (
    sleeping && $past(sleeping, 2) |-> sda_oe_n)
    else $error("data line driven while asleep");
  a_quiet_recover: assert property (recovering |-> sda_oe_n)
    else $error("data line driven while recovering");
  a_recover_bound: assert property (
    recovering |-> rec_cnt_q <= RECOVERY_CYCLES)
    else $error("recovery longer than its interval");
  a_recover_holds: assert property ($rose(recovering) |-> recovering[*8])
    else $error("recovery ended too early");
  a_recover_ends: assert property (s_recover_end |->
    standby_ready && ptr_undefined_q && rec_cnt_q >= RECOVERY_CYCLES - 1)
    else $error("recovery did not end in standby");
  a_soft_reset_pulse: assert property (
    soft_reset_q |-> !sleeping ##1 !soft_reset_q)
    else $error("soft reset pulse malformed");
endmodule

bind fram_id_sleep_ctrl fram_id_sleep_sva #(
  .RECOVERY_CYCLES(RECOVERY_CYCLES)
) u_sva (
  .ref_clk        (ref_clk),
  .reset          (reset),
  .sda_out        (sda_out),
  .sda_oe_n       (sda_oe_n),
  .sleeping       (sleeping),
  .recovering     (recovering),
  .standby_ready  (standby_ready),
  .mem_cmd_sel_q  (mem_cmd_sel_q),
  .mem_cmd_read_q (mem_cmd_read_q),
  .ptr_undefined_q(ptr_undefined_q),
  .soft_reset_q   (soft_reset_q)
);

// *** dv/i2c_master_model.sv ***
// Behavioural two-wire bus master driving the clock and data lines.
// Assumes a pull-up on data; the bench forms the wired-AND level.
`timescale 1ns/1ps

module i2c_master_model (
  output logic     scl,
  output logic     sda_m,
  input wire logic sda_line
);
  // Quarter bit time in ns; the bus clock stands still between frames.
  int q = 16;

  // Bus idles released and high.
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // One clock pulse; a released line reads back the other party.
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    #(q) scl = 1'b1;
    #(q) r = sda_line;
    #(q) scl = 1'b0;
    #(q);
  endtask
  // Start or repeated start.
  task automatic start();
    sda_m = 1'b1;
    #(q) scl = 1'b1;
    #(q) sda_m = 1'b0;
    #(q) scl = 1'b0;
    #(q);
  endtask
  // Stop, ending every sequence.
  task automatic stop();
    sda_m = 1'b0;
    #(q) scl = 1'b1;
    #(q) sda_m = 1'b1;
    #(q);
  endtask
  // Short clock spike during a low phase.
  task automatic spike(input int w);
    scl = 1'b1;
    #(w) scl = 1'b0;
    #(q);
  endtask
  // Writes a byte, MSB first, and reports whether it was acknowledged.
  task automatic wr_byte(input logic [7:0] v, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    k = !r;
  endtask
  // Reads a byte and answers with acknowledge or not.
  task automatic rd_byte(input logic k, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(!k, r);
  endtask
endmodule

// *** dv/fram_id_sleep_ctrl_tb.sv ***
// Self-checking bench for the command-extension block.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps

module fram_id_sleep_ctrl_tb;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  localparam int unsigned REC = 80;
  localparam logic [11:0] MFR = 12'h3C1; // Arbitrary value.
  localparam logic [11:0] TYP = 12'h6E4; // Arbitrary value.
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hs_mode = 1'b1;
  logic        pin_lo = 1'b0;
  logic        pin_hi = 1'b0;
  logic        scl, sda_m, sda_out, sda_oe_n, sleeping, recovering;
  logic        ready, sel, rd, b16, ptr, srst, ack;
  logic [1:0]  lo;
  logic [7:0]  d;
  logic [31:0] seed = 32'h99E2;
  int          failures = 0;
  int          checks_done = 0;
  int          sel_seen = 0;
  int          srst_seen = 0;
  int          n, s;
  wire         sda_line = sda_m & (sda_oe_n | sda_out);

  // Reference clock of 5 ns.
  always #2.5 ref_clk = ~ref_clk;

  fram_id_sleep_ctrl #(
    .RECOVERY_CYCLES(REC),
    .MANUFACTURER_ID(MFR),
    .DEVICE_TYPE_ID (TYP)
  ) dut (
    .ref_clk                (ref_clk),
    .reset                  (reset),
    .scl_in                 (scl),
    .sda_in                 (sda_line),
    .sda_out                (sda_out),
    .sda_oe_n               (sda_oe_n),
    .address_select_pin_low (pin_lo),
    .address_select_pin_high(pin_hi),
    .hs_mode                (hs_mode),
    .sleeping               (sleeping),
    .recovering             (recovering),
    .standby_ready          (ready),
    .mem_cmd_sel_q          (sel),
    .mem_cmd_read_q         (rd),
    .memory_address_bit16_q (b16),
    .ptr_undefined_q        (ptr),
    .soft_reset_q           (srst)
  );
  i2c_master_model m (.scl(scl), .sda_m(sda_m), .sda_line(sda_line));

  // Counts the one-cycle pulses of the block.
  always @(posedge ref_clk) begin
    if (sel === 1'b1) sel_seen <= sel_seen + 1;
    if (srst === 1'b1) srst_seen <= srst_seen + 1;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Own slave address with the given memory bit and direction.
  function automatic logic [7:0] own(input logic [1:0] l);
    return {4'hA, pin_hi, pin_lo, l};
  endfunction
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Waits whole cycles, then steps just past the edge.
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  // New random strap pins and address low bits.
  task automatic new_pins();
    cyc(1);
    seed = lfsr(seed);
    {pin_hi, pin_lo} = seed[3:2];
    lo = seed[1:0];
    cyc(4);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    cyc(20);
    reset = 1'b0;
    cyc(2);
    check("idle", {ready, sleeping, recovering, ptr, sda_oe_n}, 5'h13);
    for (int i = 0; i < 6; i++) begin
      new_pins();
      lo[0] = lo[0] & i[0];
      hs_mode = (i != 0);
      m.q = (i == 0) ? 100 : 16;
      n = sel_seen;
      m.start();
      if (i == 0) m.spike(30);
      m.wr_byte(own(lo), ack);
      m.stop();
      cyc(4);
      check("address ack", ack, 1'b1);
      check("select count", 24'(sel_seen - n), 24'h1);
      check("direction and bit 16", {rd, b16}, {lo[0], lo[1]});
      if (!lo[0]) check("pointer flag", ptr, 1'b0);
    end
    m.start();
    m.wr_byte(own(lo) ^ 8'h0C, ack);
    m.stop();
    check("foreign pins", ack, 1'b0);
    m.start();
    m.wr_byte(own(lo) ^ 8'h40, ack);
    m.stop();
    check("foreign code", ack, 1'b0);
    new_pins();
    m.start();
    m.wr_byte(8'hF8, ack);
    check("prefix ack", ack, 1'b1);
    m.wr_byte(own(lo), ack);
    check("id address ack", ack, 1'b1);
    m.start();
    m.wr_byte(8'hF9, ack);
    check("id command ack", ack, 1'b1);
    for (int k = 0; k < 3; k++) begin
      m.rd_byte(k < 2, d);
      check("id byte", d, 8'({MFR, TYP} >> (16 - 8 * k)));
    end
    m.stop();
    n = sel_seen;
    s = srst_seen;
    m.start();
    m.wr_byte(8'hF8, ack);
    repeat (9) m.bit_io(1'b1, ack);
    m.start();
    m.wr_byte(own(2'b00), ack);
    m.stop();
    cyc(4);
    check("soft reset", 24'(srst_seen - s), 24'h1);
    check("fresh command", 24'(sel_seen - n), 24'h1);
    new_pins();
    m.start();
    m.wr_byte(8'hF8, ack);
    m.wr_byte(own(lo), ack);
    m.start();
    m.wr_byte(8'hF8, ack);
    check("sleep ack", ack, 1'b1);
    m.stop();
    cyc(4);
    check("asleep", {sleeping, ready}, 2'b10);
    m.start();
    m.wr_byte(own(lo) ^ 8'h08, ack);
    m.stop();
    cyc(4);
    check("foreign wake", {ack, sleeping, recovering}, 3'b010);
    // A stop cut into the waking address must leave the device asleep.
    m.start();
    m.bit_io(1'b1, ack);
    m.bit_io(1'b0, ack);
    m.stop();
    cyc(4);
    check("stop while waking", {sleeping, ready}, 2'b10);
    d = own(~lo);
    m.start();
    for (int k = 0; k < 8; k++) begin
      m.bit_io(d[7 - k], ack);
      if (k == 4 || k == 5) begin
        cyc(12);
        check("wake edge", {sleeping, recovering}, k == 4 ? 2'h2 : 2'h1);
      end
    end
    m.bit_io(1'b1, ack);
    check("wake byte quiet", ack, 1'b1);
    m.stop();
    cyc(4);
    check("stop ignored", recovering, 1'b1);
    for (int t = 0; t < REC + 40 && ready !== 1'b1; t++) cyc(1);
    check("standby again", ready, 1'b1);
    if (ready !== 1'b1) close_out();
    check("pointer after wake", ptr, 1'b1);
    m.start();
    m.wr_byte(own(2'b00), ack);
    m.stop();
    cyc(4);
    check("ack after recovery", ack, 1'b1);
    check("pointer set", ptr, 1'b0);
    close_out();
  end
endmodule
